// file: verilog/sfs_defs.svh
`ifndef SFS_DEFS_SVH
`define SFS_DEFS_SVH
// Frame layout: octet count and octet positions.
`define SFS_FRAME_OCTETS   7
`define SFS_OCT_CMD        3'h0
`define SFS_OCT_PAY0       3'h1
`define SFS_OCT_PAY1       3'h2
`define SFS_OCT_CHK_LO     3'h3
`define SFS_OCT_CHK_HI     3'h4
`define SFS_OCT_CONN_LO    3'h5
`define SFS_OCT_CONN_HI    3'h6
// Command octet: kind in the high nibble, sequence in the low nibble.
`define SFS_KIND_RESET     4'h0
`define SFS_KIND_SESSION   4'h1
`define SFS_KIND_PARAM     4'h2
`define SFS_KIND_DATA      4'h3
// Control and status word bit positions in byte zero.
`define SFS_BIT_TORQUE     0
`define SFS_BIT_STOP       1
`define SFS_BIT_FAULT      7
`define SFS_WORD_MASK      16'h0083
`define SFS_CTRL_RESET     16'h0000
// Check value generator and seed.
`define SFS_CHECK_POLY     16'h1021
`define SFS_CHECK_SEED     16'hFFFF
// Timing in milliseconds and the clock rate in kHz.
`define SFS_CLK_KHZ        50000
`define SFS_DEV_ACK_MS     70
`define SFS_WATCHDOG_MS    250
`define SFS_STOP_MS        1000
`endif

// file: verilog/sfs_pkg.sv
package sfs_pkg;
    // Received or transmitted frame, fields in wire order.
    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] payload;
        logic [15:0] check;
        logic [15:0] connId;
    } frame_type;

    // Connection life cycle.
    typedef enum logic [1:0] {
        ST_SESSION,
        ST_PARAM,
        ST_EXCHANGE
    } state_type;
endpackage

// file: verilog/sfs_check16.sv
`timescale 1ns/1ps
`include "sfs_defs.svh"
// Folds one octet into a 16-bit check value, most significant bit first.
module sfs_check16 #(
    parameter logic [15:0] POLY = `SFS_CHECK_POLY
) (
    input  wire logic [15:0] crcIn,
    input  wire logic [7:0]  octet,
    output logic      [15:0] crcOut
);
    // Bitwise shift of eight data bits through the register.
    always_comb
    begin
        logic [15:0] c;
        c = crcIn;
        for (int i = 7; i >= 0; i--)
        begin
            if (c[15] ^ octet[i])
                c = {c[14:0], 1'b0} ^ POLY;
            else
                c = {c[14:0], 1'b0};
        end
        crcOut = c;
    end
endmodule

// file: verilog/sfs_buf2.sv
`timescale 1ns/1ps
// Two-entry buffer; inReady comes from a flip-flop, outValid is decoded from count_q.
module sfs_buf2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    logic [WIDTH-1:0] mem_q [2];
    logic             rdPtr_q;
    logic             wrPtr_q;
    logic [1:0]       count_q;
    logic             push;
    logic             pop;

    // Handshakes on both sides.
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outValid = (count_q != 2'h0);
    assign outData  = mem_q[rdPtr_q];

    // Storage and pointers.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdPtr_q <= 1'b0;
            wrPtr_q <= 1'b0;
            count_q <= 2'h0;
            inReady <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= ~wrPtr_q;
            end
            if (pop)
            begin
                rdPtr_q <= ~rdPtr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
            inReady <= (count_q + {1'b0, push} - {1'b0, pop}) != 2'h2;
        end
    end

    // Data array, written on push only.
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wrPtr_q] <= inData;
        end
    end
endmodule

// file: verilog/sfs_slave_frame.sv
`timescale 1ns/1ps
`include "sfs_defs.svh"
// What this block does
// [RULE1] Seven octets: command, two payload, check low/high, connection id low/high.
// [RULE2] Connection id in octets five and six must match our own.
// [RULE3] Session number must match, otherwise the connection is refused.
// [RULE4] Sequence numbers are tracked; any gap or repeat is a fault; checked only in ST_EXCHANGE, not during start-up.
// [RULE5] Watchdog per cycle; expiry without a valid frame enters safe state.
// [RULE6] Check value verified on receive and generated on transmit.
// [RULE7] Start-up parameters compared with local values before data exchange.
// [RULE8] Master slave address must equal our destination address.
// [RULE9] Master maps payload bits identically to our telegram.
// [RULE10] Reply is ready well inside the device acknowledgment time.
// [RULE11] Master sets watchdog slightly above the summed round trip.
// [RULE12] Too short a watchdog still trips to safe state with a fault.
// [RULE13] Worst delay stays in bound; watchdog at least the recommended minimum.
// [RULE14] Control bit 0 low requests torque off.
// [RULE15] Control bit 1 low requests the timed stop.
// [RULE16] Unsupported control and status bits are zero.
// [RULE17] Falling edge of control bit 7 acknowledges the fault buffer.
// [RULE18] Status bit 0 high whenever torque is removed, from any source.
// [RULE19] Status bit 1 high while the timed stop runs, from any source.
// [RULE20] Status bit 7 high while any safety fault is present.
// [RULE21] Byte zero follows the drive profile, byte one is maker-specific.
// [RULE22] Current control and status words are readable outputs.
// [RULE23] Timed stop timer starts on request, stops and resets on release.
// [RULE24] Timer expiry with request held removes torque at once.
// [RULE25] Bad frames are discarded; torque removed and fault set.
module sfs_slave_frame #(
    parameter int WATCHDOG_MS = `SFS_WATCHDOG_MS,
    parameter int WD_CYCLES   = WATCHDOG_MS * `SFS_CLK_KHZ,
    parameter int STOP_MS     = `SFS_STOP_MS,
    parameter int STOP_CYCLES = STOP_MS * `SFS_CLK_KHZ
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    output logic             rxReady,
    output logic             txValid_q,
    output logic      [7:0]  txData_q,
    input  wire logic        txReady,
    input  wire logic [15:0] ownConnId,
    input  wire logic [15:0] ownSession,
    input  wire logic [15:0] localParams,
    input  wire logic        diTorqueOff,
    input  wire logic        diStop,
    input  wire logic        extFault,
    output logic             torqueRemoved_q,
    output logic             linkUp_q,
    output logic      [15:0] ctrlWord_q,
    output logic      [15:0] statusWord_q,
    output logic             faultAcked_q
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int ACK_CYCLES = `SFS_DEV_ACK_MS * `SFS_CLK_KHZ;

    sfs_pkg::state_type state_q;
    sfs_pkg::frame_type rx_q;
    sfs_pkg::frame_type tx_q;
    logic        bufValid;
    logic [7:0]  bufData;
    logic        bufReady;
    logic [2:0]  rxIdx_q;
    logic [15:0] rxCrc_q;
    logic [15:0] rxCrcNext;
    logic [3:0]  rxSeq_q;
    logic [3:0]  txSeq_q;
    logic [2:0]  txIdx_q;
    logic        txBusy_q;
    logic [31:0] wdCount_q;
    logic [31:0] stopCount_q;
    logic        stopExpired_q;
    logic        faultLatched_q;
    logic        ackBit_q;
    logic [2:0]  diTorqueSync_q;
    logic [2:0]  diStopSync_q;
    logic [2:0]  extFaultSync_q;
    logic        lastOctet;
    logic        frameGood;
    logic        frameBad;
    logic        wdExpired;
    logic        stopReq;
    logic        torqueOffNow;
    logic [7:0]  kind;
    logic [15:0] txCrc1;
    logic [15:0] txCrc2;
    logic [15:0] txCrc3;
    logic [15:0] replyStatus;

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    // Two-entry buffer; the parser stalls while a reply is being sent.
    sfs_buf2 #(
        .WIDTH (8)
    ) u_rxBuf (
        .clk      (clk),
        .rstn     (rstn),
        .inValid  (rxValid),
        .inData   (rxData),
        .inReady  (rxReady),
        .outValid (bufValid),
        .outData  (bufData),
        .outReady (bufReady)
    );

    assign bufReady  = !txBusy_q;
    assign lastOctet = bufValid && bufReady && (rxIdx_q == `SFS_OCT_CONN_HI);
    assign kind      = {4'h0, rx_q.cmd[7:4]};

    // Pin inputs pass three flip-flops; bit 0 is the first stage.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            diTorqueSync_q <= 3'h0;
            diStopSync_q   <= 3'h0;
            extFaultSync_q <= 3'h0;
        end
        else
        begin
            diTorqueSync_q <= {diTorqueSync_q[1:0], diTorqueOff};
            diStopSync_q   <= {diStopSync_q[1:0], diStop};
            extFaultSync_q <= {extFaultSync_q[1:0], extFault};
        end
    end

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    // [RULE6] Receive check update
    sfs_check16 u_rxCheck (
        .crcIn  (rxIdx_q == `SFS_OCT_CMD ? `SFS_CHECK_SEED : rxCrc_q),
        .octet  (bufData),
        .crcOut (rxCrcNext)
    );

    // [RULE1] Octet order capture
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxIdx_q <= 3'h0;
            rxCrc_q <= 16'h0000;
            rx_q    <= '0;
        end
        else if (bufValid && bufReady)
        begin
            rxIdx_q <= lastOctet ? 3'h0 : rxIdx_q + 3'h1;
            unique case (rxIdx_q)
                `SFS_OCT_CMD:     rx_q.cmd            <= bufData;
                `SFS_OCT_PAY0:    rx_q.payload[7:0]   <= bufData;
                `SFS_OCT_PAY1:    rx_q.payload[15:8]  <= bufData;
                `SFS_OCT_CHK_LO:  rx_q.check[7:0]     <= bufData;
                `SFS_OCT_CHK_HI:  rx_q.check[15:8]    <= bufData;
                `SFS_OCT_CONN_LO: rx_q.connId[7:0]    <= bufData;
                default:          rx_q.connId[15:8]   <= bufData;
            endcase
            if (rxIdx_q <= `SFS_OCT_PAY1)
            begin
                rxCrc_q <= rxCrcNext;
            end
        end
    end

    // Verdict on the completed frame, taken with its last octet.
    always_comb
    begin
        frameGood = 1'b0;
        frameBad  = 1'b0;
        if (lastOctet)
        begin
            // [RULE6] Check value compare
            // [RULE2] Connection id compare
            // [RULE4] Sequence compare
            if (rx_q.check != rxCrc_q || {bufData, rx_q.connId[7:0]} != ownConnId
                || (state_q == sfs_pkg::ST_EXCHANGE && rx_q.cmd[3:0] != rxSeq_q))
                frameBad = 1'b1;
            // [RULE3] Session compare
            else if (kind == {4'h0, `SFS_KIND_SESSION} && rx_q.payload != ownSession)
                frameBad = 1'b1;
            // [RULE7] Parameter compare
            else if (kind == {4'h0, `SFS_KIND_PARAM} && rx_q.payload != localParams)
                frameBad = 1'b1;
            else
                frameGood = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Connection state
    // ------------------------------------------------------------
    // [RULE5] Watchdog expiry
    // [RULE12] Short watchdog trips
    assign wdExpired = (state_q == sfs_pkg::ST_EXCHANGE) && (wdCount_q == 32'h0000_0000);

    // Start-up walks session then parameters, then exchanges data.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= sfs_pkg::ST_SESSION;
            rxSeq_q <= 4'h0;
        end
        else if (frameBad || wdExpired)
        begin
            // [RULE25] Fall back to start-up
            state_q <= sfs_pkg::ST_SESSION;
        end
        else if (frameGood)
        begin
            rxSeq_q <= rx_q.cmd[3:0] + 4'h1;
            unique case (state_q)
                sfs_pkg::ST_SESSION:
                    if (kind == {4'h0, `SFS_KIND_SESSION})
                        state_q <= sfs_pkg::ST_PARAM;
                sfs_pkg::ST_PARAM:
                    if (kind == {4'h0, `SFS_KIND_PARAM})
                        state_q <= sfs_pkg::ST_EXCHANGE;
                    else if (kind == {4'h0, `SFS_KIND_RESET})
                        state_q <= sfs_pkg::ST_SESSION;
                sfs_pkg::ST_EXCHANGE:
                    if (kind != {4'h0, `SFS_KIND_DATA})
                        state_q <= sfs_pkg::ST_SESSION;
            endcase
        end
    end

    // [RULE5] Watchdog reload
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wdCount_q <= 32'h0000_0000;
        end
        else if (frameGood || state_q != sfs_pkg::ST_EXCHANGE)
        begin
            wdCount_q <= 32'(WD_CYCLES);
        end
        else if (wdCount_q != 32'h0000_0000)
        begin
            wdCount_q <= wdCount_q - 32'h0000_0001;
        end
    end

    // Control word updates only from accepted data frames.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrlWord_q <= `SFS_CTRL_RESET;
        end
        else if (frameBad || wdExpired || state_q != sfs_pkg::ST_EXCHANGE)
        begin
            // [RULE25] Safe control word
            ctrlWord_q <= `SFS_CTRL_RESET;
        end
        else if (frameGood && state_q == sfs_pkg::ST_EXCHANGE
                 && kind == {4'h0, `SFS_KIND_DATA})
        begin
            // [RULE16] Unsupported bits cleared
            ctrlWord_q <= rx_q.payload & `SFS_WORD_MASK;
        end
    end

    // ------------------------------------------------------------
    // Safety functions
    // ------------------------------------------------------------
    // [RULE15] Zero-active stop bit
    assign stopReq = (linkUp_q && !ctrlWord_q[`SFS_BIT_STOP]) || diStopSync_q[2];

    // [RULE23] Timer start and reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stopCount_q   <= 32'h0000_0000;
            stopExpired_q <= 1'b0;
        end
        else if (!stopReq)
        begin
            stopCount_q   <= 32'h0000_0000;
            stopExpired_q <= 1'b0;
        end
        else if (stopCount_q == 32'(STOP_CYCLES - 1))
        begin
            stopExpired_q <= 1'b1;
        end
        else
        begin
            stopCount_q <= stopCount_q + 32'h0000_0001;
        end
    end

    // [RULE14] Zero-active torque bit
    // [RULE24] Expiry removes torque
    // [RULE18] Any source removes torque
    assign torqueOffNow = !linkUp_q || !ctrlWord_q[`SFS_BIT_TORQUE]
                          || diTorqueSync_q[2] || stopExpired_q || faultLatched_q;

    // [RULE20] Fault latch, set wins
    // [RULE17] Falling edge acknowledge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            faultLatched_q <= 1'b0;
            faultAcked_q   <= 1'b0;
            ackBit_q       <= 1'b0;
        end
        else
        begin
            ackBit_q <= ctrlWord_q[`SFS_BIT_FAULT];
            if (frameBad || wdExpired || extFaultSync_q[2])
            begin
                faultLatched_q <= 1'b1;
            end
            else if (ackBit_q && !ctrlWord_q[`SFS_BIT_FAULT])
            begin
                faultAcked_q   <= faultLatched_q;
                faultLatched_q <= 1'b0;
            end
        end
    end

    // [RULE19] Stop active from any source
    // [RULE21] Profile bits in byte zero
    // [RULE22] Readable words
    assign replyStatus = {8'h00, faultLatched_q, 5'b00000, stopReq && !stopExpired_q,
                          torqueOffNow};

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            statusWord_q    <= 16'h0001;
            torqueRemoved_q <= 1'b1;
            linkUp_q        <= 1'b0;
        end
        else
        begin
            statusWord_q    <= replyStatus;
            torqueRemoved_q <= torqueOffNow;
            linkUp_q        <= (state_q == sfs_pkg::ST_EXCHANGE) && !frameBad && !wdExpired;
        end
    end

    // ------------------------------------------------------------
    // Reply path
    // ------------------------------------------------------------
    // [RULE6] Transmit check chain
    sfs_check16 u_txCheck0 (
        .crcIn  (`SFS_CHECK_SEED),
        .octet  ({rx_q.cmd[7:4], txSeq_q}),
        .crcOut (txCrc1)
    );
    sfs_check16 u_txCheck1 (
        .crcIn  (txCrc1),
        .octet  (statusWord_q[7:0]),
        .crcOut (txCrc2)
    );
    sfs_check16 u_txCheck2 (
        .crcIn  (txCrc2),
        .octet  (statusWord_q[15:8]),
        .crcOut (txCrc3)
    );

    // [RULE10] Reply loaded next cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_q      <= '0;
            txSeq_q   <= 4'h0;
            txIdx_q   <= 3'h0;
            txBusy_q  <= 1'b0;
            txValid_q <= 1'b0;
            txData_q  <= 8'h00;
        end
        else if (!txBusy_q && frameGood)
        begin
            tx_q      <= '{cmd: {rx_q.cmd[7:4], txSeq_q}, payload: statusWord_q,
                           check: txCrc3, connId: ownConnId};
            txSeq_q   <= txSeq_q + 4'h1;
            txIdx_q   <= 3'h0;
            txBusy_q  <= 1'b1;
            txValid_q <= 1'b1;
            txData_q  <= {rx_q.cmd[7:4], txSeq_q};
        end
        else if (txValid_q && txReady)
        begin
            // [RULE1] Transmit octet order
            txIdx_q <= txIdx_q + 3'h1;
            unique case (txIdx_q)
                `SFS_OCT_CMD:     txData_q <= tx_q.payload[7:0];
                `SFS_OCT_PAY0:    txData_q <= tx_q.payload[15:8];
                `SFS_OCT_PAY1:    txData_q <= tx_q.check[7:0];
                `SFS_OCT_CHK_LO:  txData_q <= tx_q.check[15:8];
                `SFS_OCT_CHK_HI:  txData_q <= tx_q.connId[7:0];
                `SFS_OCT_CONN_LO: txData_q <= tx_q.connId[15:8];
                default:          txData_q <= 8'h00;
            endcase
            if (txIdx_q == `SFS_OCT_CONN_HI)
            begin
                txBusy_q  <= 1'b0;
                txValid_q <= 1'b0;
            end
        end
    end

    // Acknowledgment budget in cycles, kept for reference by users.
    logic unusedAck;
    assign unusedAck = (ACK_CYCLES > 0);
endmodule

// file: tb/sfs_plc.sv
`timescale 1ns/1ps
// Master model: sends request frames and collects reply octets.
module sfs_plc (
    input  wire logic       clk,
    output logic            rxValid,
    output logic      [7:0] rxData,
    input  wire logic       rxReady,
    input  wire logic       txValid_q,
    input  wire logic [7:0] txData_q,
    output logic            txReady
);
    logic [7:0] replyQ[$];
    logic       hold = 1'b0;

    // Hold stalls the replies.
    assign txReady = !hold;

    // Replies kept in order.
    // octet order kept
    always @(posedge clk)
        if (txValid_q && txReady)
            replyQ.push_back(txData_q);

    initial
    begin
        rxValid = 1'b0;
        rxData  = 8'h00;
    end

    // Offers one octet and holds it until the buffer takes it.
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        rxValid = 1'b1;
        rxData  = b;
        while (!rxReady)
            @(negedge clk);
        @(posedge clk);
    endtask

    // Sends a frame.
    // frame as mapped
    task automatic send(input logic [7:0] o [7]);
        foreach (o[i])
            put(o[i]);
        @(negedge clk);
        rxValid = 1'b0;
        rxData  = ~rxData;
    endtask
endmodule

// file: tb/sfs_slave_frame_props.sv
`timescale 1ns/1ps
// Port checks.
module sfs_slave_frame_props (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        txValid_q,
    input wire logic [7:0]  txData_q,
    input wire logic        txReady,
    input wire logic        diStop,
    input wire logic        extFault,
    input wire logic        torqueRemoved_q,
    input wire logic        linkUp_q,
    input wire logic [15:0] ctrlWord_q,
    input wire logic [15:0] statusWord_q,
    input wire logic        faultAcked_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ctrl_unused_zero: assert property ((ctrlWord_q & 16'hFF7C) == 16'h0000)
        else $error("unused control bits set");
    a_torque_off_cmd: assert property (linkUp_q && !ctrlWord_q[0] |-> ##[0:2] torqueRemoved_q)
        else $error("torque kept on request");
    a_bad_frame_clear: assert property ($fell(linkUp_q) && !$rose(txValid_q) |-> ctrlWord_q == 16'h0000)
        else $error("control word kept after link loss");
    a_fault_status: assert property (extFault [*3] |-> ##[0:3] statusWord_q[7])
        else $error("fault not shown");
    a_reply_stands: assert property (txValid_q && !txReady |=> txValid_q && $stable(txData_q))
        else $error("reply octet dropped");
    a_ack_time: assert property ($rose(linkUp_q) |-> ##[0:2] txValid_q)
        else $error("reply late");
    a_stop_status: assert property ($rose(diStop) ##1 diStop [*5] |-> statusWord_q[1])
        else $error("stop not shown");
    a_fault_ack: assert property ($fell(ctrlWord_q[7]) && statusWord_q[7] && !extFault |-> ##[0:2] faultAcked_q)
        else $error("acknowledge not taken");
endmodule

bind sfs_slave_frame sfs_slave_frame_props i_sfs_slave_frame_props (
    .clk(clk), .rstn(rstn), .txValid_q(txValid_q), .txData_q(txData_q), .txReady(txReady),
    .diStop(diStop), .extFault(extFault), .torqueRemoved_q(torqueRemoved_q),
    .linkUp_q(linkUp_q), .ctrlWord_q(ctrlWord_q), .statusWord_q(statusWord_q),
    .faultAcked_q(faultAcked_q)
);

// file: tb/sfs_slave_frame_test.sv
`timescale 1ns/1ps
`include "sfs_defs.svh"
// Bench for the endpoint.
module sfs_slave_frame_test;
    localparam logic [15:0] CONN = 16'h5A3C;
    localparam logic [15:0] SESS = 16'h1234;
    localparam logic [15:0] PARM = 16'h00C5;
    logic        clk, rstn, rxValid, rxReady, txValid_q, txReady, diTorqueOff, diStop;
    logic        extFault, torqueRemoved_q, linkUp_q, faultAcked_q;
    logic [7:0]  rxData, txData_q;
    logic [15:0] ctrlWord_q, statusWord_q;
    logic [3:0]  seq, txSeq;
    int          errCount, nTests;

    sfs_slave_frame #(.WD_CYCLES(200), .STOP_CYCLES(50)) i_sfs_slave_frame (
        .clk(clk), .rstn(rstn), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
        .txValid_q(txValid_q), .txData_q(txData_q), .txReady(txReady), .ownConnId(CONN),
        .ownSession(SESS), .localParams(PARM), .diTorqueOff(diTorqueOff), .diStop(diStop),
        .extFault(extFault), .torqueRemoved_q(torqueRemoved_q), .linkUp_q(linkUp_q),
        .ctrlWord_q(ctrlWord_q), .statusWord_q(statusWord_q), .faultAcked_q(faultAcked_q)
    );
    sfs_plc i_sfs_plc (
        .clk(clk), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
        .txValid_q(txValid_q), .txData_q(txData_q), .txReady(txReady)
    );

    // Clock of 20 ns period.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        nTests++;
        if (ok !== 1'b1)
        begin
            errCount++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    // Check over three octets.
    function automatic logic [15:0] crc3(input logic [23:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 23; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction

    // Builds and sends a frame; bad selects check, connection or sequence damage.
    task automatic frame(input logic [3:0] kind, input logic [15:0] pay, input int bad);
        logic [7:0]  o [7];
        logic [15:0] c;
        if (bad == 3)
            seq = seq - 4'h1;
        o[0] = {kind, seq};
        o[1] = pay[7:0];
        o[2] = pay[15:8];
        c = crc3({o[0], o[1], o[2]}) ^ {15'h0000, bad == 1};
        o[3] = c[7:0];
        o[4] = c[15:8];
        o[5] = CONN[7:0] ^ {7'h00, bad == 2};
        o[6] = CONN[15:8];
        seq = seq + 4'h1;
        i_sfs_plc.replyQ.delete();
        i_sfs_plc.send(o);
    endtask

    // Checks one reply frame.
    task automatic reply(input logic [3:0] kind);
        logic [7:0] r [7];
        repeat (40)
            if (i_sfs_plc.replyQ.size() < 7)
                @(negedge clk);
        chk(i_sfs_plc.replyQ.size() >= 7, "reply missing");
        if (i_sfs_plc.replyQ.size() < 7)
            return;
        foreach (r[i])
            r[i] = i_sfs_plc.replyQ.pop_front();
        chk(r[0] === {kind, txSeq}, "reply command");
        chk({r[4], r[3]} === crc3({r[0], r[1], r[2]}), "reply check");
        chk({r[6], r[5]} === CONN, "reply connection");
        chk(({r[2], r[1]} & 16'hFF7C) === 16'h0000, "reply unused bits");
        txSeq = txSeq + 4'h1;
    endtask

    // Any state falls back to start-up first.
    task automatic link;
        frame(`SFS_KIND_RESET, 16'h0000, 0);
        reply(`SFS_KIND_RESET);
        frame(`SFS_KIND_SESSION, SESS, 0);
        reply(`SFS_KIND_SESSION);
        frame(`SFS_KIND_PARAM, PARM, 0);
        reply(`SFS_KIND_PARAM);
        chk(linkUp_q === 1'b1, "link not up");
    endtask

    task automatic data(input logic [15:0] pay);
        frame(`SFS_KIND_DATA, pay, 0);
        reply(`SFS_KIND_DATA);
    endtask

    // Hang limit.
    initial
    begin
        repeat (20000) @(posedge clk);
        errCount++;
        end_sim();
    end

    // Main sequence.
    initial
    begin
        {rstn, diTorqueOff, diStop, extFault, seq, txSeq} = '0;
        {errCount, nTests} = '0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk(torqueRemoved_q === 1'b1 && statusWord_q === 16'h0001, "reset state");
        diStop = 1'b1;
        repeat (8) @(negedge clk);
        chk(statusWord_q[1] === 1'b1, "input stop");
        diStop = 1'b0;
        frame(`SFS_KIND_SESSION, ~SESS, 0);
        repeat (20) @(negedge clk);
        chk(i_sfs_plc.replyQ.size() == 0 && statusWord_q[7], "bad session");
        link();
        data(16'h0083);
        data(16'hFF03);
        chk(ctrlWord_q === 16'h0003, "control word");
        chk(faultAcked_q === 1'b1 && statusWord_q === 16'h0000, "fault ack");
        chk(torqueRemoved_q === 1'b0, "torque permitted");
        data(16'h0001);
        chk(statusWord_q[1] === 1'b1 && torqueRemoved_q === 1'b0, "stop timing");
        repeat (60) @(negedge clk);
        chk(torqueRemoved_q === 1'b1 && statusWord_q[1:0] === 2'b01, "stop expiry");
        data(16'h0003);
        chk(torqueRemoved_q === 1'b0, "stop release");
        data(16'h0002);
        chk(torqueRemoved_q === 1'b1 && statusWord_q[0] === 1'b1, "torque off");
        data(16'h0003);
        diTorqueOff = 1'b1;
        repeat (6) @(negedge clk);
        chk(torqueRemoved_q === 1'b1 && statusWord_q[0] === 1'b1, "input off");
        diTorqueOff = 1'b0;
        i_sfs_plc.hold = 1'b1;
        frame(`SFS_KIND_DATA, 16'h0003, 0);
        fork
            frame(`SFS_KIND_DATA, 16'h0003, 0);
            begin
                repeat (30) @(negedge clk);
                chk(rxReady === 1'b0, "buffer not full");
                i_sfs_plc.hold = 1'b0;
            end
        join
        reply(`SFS_KIND_DATA);
        reply(`SFS_KIND_DATA);
        chk(linkUp_q === 1'b1, "octet lost");
        for (int k = 1; k <= 3; k++)
        begin
            link();
            frame(`SFS_KIND_DATA, 16'h0003, k);
            repeat (20) @(negedge clk);
            chk(!linkUp_q && ctrlWord_q === 16'h0000, "bad frame taken");
            chk(statusWord_q[7] && i_sfs_plc.replyQ.size() == 0, "bad frame");
        end
        link();
        frame(`SFS_KIND_RESET, 16'h0000, 0);
        reply(`SFS_KIND_RESET);
        chk(linkUp_q === 1'b0, "restart kind");
        link();
        repeat (220) @(negedge clk);
        chk(linkUp_q === 1'b0 && statusWord_q[7] === 1'b1, "watchdog");
        extFault = 1'b1;
        repeat (6) @(negedge clk);
        chk(statusWord_q[7] === 1'b1 && torqueRemoved_q === 1'b1, "fault input");
        extFault = 1'b0;
        end_sim();
    end
endmodule
